/* hdl/cs_dev_pkg.sv */
// constants, encodings and timing-free layouts for the cycle-steal device
package cs_dev_pkg;
   // channel command codes (immediate command block, bits 0-7)
   localparam logic [7:0] CMD_READ_STATUS = 8'h2F;
   localparam logic [7:0] CMD_PREPARE = 8'h60;
   localparam logic [7:0] CMD_CONTROL = 8'h61;
   localparam logic [7:0] CMD_DEV_RESET = 8'h6F;
   localparam logic [7:0] CMD_START = 8'h70;
   localparam logic [7:0] CMD_START_STS = 8'h7F;
   // instruction condition codes
   localparam logic [2:0] ICC_BUSY = 3'h1;
   localparam logic [2:0] ICC_REJECT = 3'h3;
   localparam logic [2:0] ICC_OK = 3'h7;
   // interrupt condition codes
   localparam logic [2:0] IRQ_CC_PCI = 3'h1;
   localparam logic [2:0] IRQ_CC_EXCEPT = 3'h2;
   localparam logic [2:0] IRQ_CC_DEV_END = 3'h3;
   // control word bits, index into [15:0] (control-word bit 0 is the msb)
   localparam int CW_CHAIN = 15;
   localparam int CW_PCI = 14;
   localparam int CW_SE = 13;
   localparam int CW_BYTE = 7;
   localparam int CW_INPUT = 6;
   localparam int CW_BURST = 0;
   // transfer control block word indexes
   localparam logic [2:0] TCB_CTRL = 3'h0;
   localparam logic [2:0] TCB_P3 = 3'h3;
   localparam logic [2:0] TCB_P4 = 3'h4;
   localparam logic [2:0] TCB_P5 = 3'h5;
   localparam logic [2:0] TCB_COUNT = 3'h6;
   localparam logic [2:0] TCB_DADDR = 3'h7;
   // interrupt status byte bits
   localparam int ISB_SPEC_CHECK = 3;
   localparam int ISB_STORAGE_ERR = 2;
   localparam int ISB_DEV_EXCEPT = 1;
   // residual status block word 1 bits
   localparam int RSB_EOC = 15;
   localparam int RSB_NE = 14;
   localparam int RSB_FLAG = 0;
   localparam logic [2:0] RSB_WORDS = 3'h2;
   // status collection: residual address, residual count, device status
   localparam logic [2:0] STS_WORDS = 3'h3;
   localparam logic [15:0] STS_MAX_COUNT = 16'h0006;
   // device identity and orientation (address value arbitrary)
   localparam logic [7:0] DEV_ADDR = 8'h5A;
   localparam logic WORD_DEVICE = 1'b1;
   localparam logic [15:0] RESADDR_POR_WORD = 16'h0001;
   localparam logic [15:0] RESADDR_POR_BYTE = 16'h0000;
   // register port offsets and control reset value
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_RESADDR = 8'h08;
   localparam logic [7:0] REG_RESCNT = 8'h0C;
   localparam logic [7:0] REG_DEVSTAT = 8'h10;
   localparam logic [1:0] CTRL_RESET = 2'h3;
   localparam int CTRL_SE_EN = 0;
   localparam int CTRL_PCI_EN = 1;

   typedef enum logic [2:0] {S_IDLE, S_FETCH, S_XFER, S_RSB, S_SSTORE} state_t;
endpackage

/* hdl/cs_dev.sv */
// device-side cycle-steal engine with direct program transfer commands
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module cs_dev
   import cs_dev_pkg::*;
(
   // clock and power-on reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // other reset sources, one-cycle pulses
   input wire logic i_sys_reset,
   input wire logic i_halt_io,
   input wire logic i_machine_check,
   // direct program transfer command
   input wire logic i_cmd_valid,
   input wire logic [7:0] i_cmd_code,
   input wire logic [15:0] i_cmd_data,
   output logic o_icc_valid,
   output logic [2:0] o_icc,
   output logic [15:0] o_icc_data,
   // cycle-steal storage access
   output logic o_cs_req,
   output logic o_cs_write,
   output logic o_cs_byte,
   output logic [15:0] o_cs_addr,
   output logic [15:0] o_cs_wdata,
   output logic o_burst,
   input wire logic i_cs_grant,
   input wire logic i_cs_error,
   input wire logic [15:0] i_cs_rdata,
   // priority interrupt
   output logic o_irq_req,
   output logic [1:0] o_irq_level,
   input wire logic i_irq_accept,
   output logic o_irq_valid,
   output logic [2:0] o_irq_cc,
   output logic [15:0] o_irq_id,
   // device-side data
   input wire logic i_dev_valid,
   input wire logic [15:0] i_dev_data,
   output logic o_dev_ready,
   output logic o_dev_wstrobe,
   output logic [15:0] o_dev_wdata,
   input wire logic i_dev_exception,
   // register port
   input wire logic [7:0] i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [15:0] o_reg_rdata
);

   typedef struct packed {
      state_t st;
      logic [2:0] widx;
      logic sts_op;
      logic busy;
      logic mask;
      logic [1:0] level;
      logic [1:0] ctrl;
      logic [15:0] dcb_addr;
      logic [15:0] cw;
      logic [15:0] p3;
      logic [15:0] p4;
      logic [15:0] p5;
      logic [15:0] cnt;
      logic [15:0] daddr;
      logic [15:0] rescnt;
      logic [15:0] resaddr;
      logic [7:0] interrupt_status_byte;
      logic supp;
      logic irq_pend;
      logic irq_term;
      logic [2:0] irq_cc;
      logic [7:0] irq_info;
      logic icc_valid;
      logic [2:0] icc;
      logic [15:0] icc_data;
      logic cs_req;
      logic cs_write;
      logic cs_byte;
      logic [15:0] cs_addr;
      logic [15:0] cs_wdata;
      logic dev_wstrobe;
      logic [15:0] dev_wdata;
      logic irq_valid;
      logic [2:0] irq_out_cc;
      logic [15:0] irq_out_id;
      logic [15:0] rdata;
   } regs_t;

   regs_t r_reg;
   regs_t r_next;

   function automatic logic is_odd(input logic [15:0] a);
      return a[0];
   endfunction

   function automatic logic [15:0] word_at(input logic [15:0] base, input logic [2:0] idx);
      return base + {12'h000, idx, 1'b0};
   endfunction

   // bytes moved by one data cycle; a trailing odd byte goes as a byte cycle
   function automatic logic [15:0] step_of(input logic byte_mode, input logic [15:0] cnt);
      return (byte_mode || cnt == 16'h0001) ? 16'h0001 : 16'h0002;
   endfunction

   logic abort;
   logic dev_take;
   logic irq_show;
   logic [15:0] xstep;

   assign abort = i_sys_reset | i_halt_io | i_machine_check;
   assign xstep = step_of(r_reg.cw[CW_BYTE], r_reg.cnt);
   // burst keeps the channel, so no interrupt is offered meanwhile
   assign irq_show = r_reg.irq_pend & r_reg.mask & ~o_burst;
   assign dev_take = (r_reg.st == S_XFER) & ~r_reg.cs_req & r_reg.cw[CW_INPUT]
                     & (r_reg.cnt != 16'h0000) & i_dev_valid & ~i_dev_exception;

   always_comb begin
      logic exc;
      logic done_dcb;
      logic [7:0] exc_bits;
      logic raise;
      exc = 1'b0;
      done_dcb = 1'b0;
      exc_bits = 8'h00;
      raise = 1'b0;
      r_next = r_reg;
      r_next.icc_valid = 1'b0;
      r_next.dev_wstrobe = 1'b0;
      r_next.irq_valid = 1'b0;
      r_next.rdata = 16'h0000;

      // register port
      if (i_reg_wr && i_reg_addr == REG_CTRL) begin
         r_next.ctrl = i_reg_wdata[1:0];
      end
      if (i_reg_rd) begin
         unique case (i_reg_addr)
            REG_CTRL: r_next.rdata = {14'h0000, r_reg.ctrl};
            REG_STATUS: r_next.rdata = {8'h00, r_reg.irq_pend, r_reg.mask, r_reg.level,
                                        r_reg.busy, r_reg.st};
            REG_RESADDR: r_next.rdata = r_reg.resaddr;
            REG_RESCNT: r_next.rdata = r_reg.rescnt;
            REG_DEVSTAT: r_next.rdata = {8'h00, r_reg.interrupt_status_byte};
            default: r_next.rdata = 16'h0000;
         endcase
      end

      // direct program transfer: code returned the cycle after the command
      if (i_cmd_valid) begin
         r_next.icc_valid = 1'b1;
         r_next.icc = ICC_OK;
         r_next.icc_data = 16'h0000;
         if (i_cmd_code != CMD_START_STS) begin
            r_next.interrupt_status_byte = 8'h00;
         end
         unique case (i_cmd_code)
            CMD_READ_STATUS: r_next.icc_data = {8'h00, r_reg.interrupt_status_byte};
            CMD_PREPARE: begin
               r_next.mask = i_cmd_data[0];
               r_next.level = i_cmd_data[9:8];
            end
            CMD_CONTROL: begin
               if (i_cmd_data[0] && !r_reg.busy) begin
                  r_next.irq_pend = 1'b1;
                  raise = 1'b1;
                  r_next.irq_term = 1'b0;
                  r_next.irq_cc = IRQ_CC_DEV_END;
                  r_next.irq_info = 8'h00;
               end
            end
            CMD_DEV_RESET: begin
               r_next.busy = 1'b0;
               r_next.irq_pend = 1'b0;
               r_next.st = S_IDLE;
               r_next.cs_req = 1'b0;
               r_next.rescnt = 16'h0000;
            end
            CMD_START, CMD_START_STS: begin
               if (r_reg.busy) begin
                  r_next.icc = ICC_BUSY;
               end else if (is_odd(i_cmd_data)) begin
                  r_next.icc = ICC_REJECT;
               end else begin
                  r_next.icc = ICC_OK;
                  r_next.busy = 1'b1;
                  r_next.irq_pend = 1'b0;
                  r_next.dcb_addr = i_cmd_data;
                  r_next.sts_op = (i_cmd_code == CMD_START_STS);
                  // status block only needs count and address words
                  r_next.widx = (i_cmd_code == CMD_START_STS) ? TCB_COUNT : TCB_CTRL;
                  r_next.supp = 1'b0;
                  r_next.st = S_FETCH;
               end
            end
            default: r_next.icc = ICC_OK;
         endcase
      end

      unique case (r_reg.st)
         S_IDLE: ;
         S_FETCH: begin
            if (!r_reg.cs_req) begin
               r_next.cs_req = 1'b1;
               r_next.cs_write = 1'b0;
               r_next.cs_byte = 1'b0;
               r_next.cs_addr = word_at(r_reg.dcb_addr, r_reg.widx);
               if (!r_reg.sts_op) begin
                  r_next.resaddr = word_at(r_reg.dcb_addr, r_reg.widx);
               end
            end else if (i_cs_grant) begin
               r_next.cs_req = 1'b0;
               if (i_cs_error) begin
                  exc = 1'b1;
                  exc_bits[ISB_STORAGE_ERR] = 1'b1;
               end else begin
                  unique case (r_reg.widx)
                     TCB_CTRL: r_next.cw = i_cs_rdata;
                     TCB_P3: r_next.p3 = i_cs_rdata;
                     TCB_P4: r_next.p4 = i_cs_rdata;
                     TCB_P5: r_next.p5 = i_cs_rdata;
                     TCB_COUNT: begin
                        r_next.cnt = i_cs_rdata;
                        if (!r_reg.sts_op) begin
                           r_next.rescnt = i_cs_rdata;
                        end
                     end
                     TCB_DADDR: r_next.daddr = i_cs_rdata;
                     default: ;
                  endcase
                  r_next.widx = r_reg.widx + 3'h1;
                  if (r_reg.widx == TCB_DADDR && r_reg.sts_op) begin
                     if (r_reg.cnt > STS_MAX_COUNT || is_odd(r_reg.cnt)
                         || is_odd(i_cs_rdata)) begin
                        exc = 1'b1;
                        exc_bits[ISB_SPEC_CHECK] = 1'b1;
                     end else begin
                        r_next.widx = 3'h0;
                        r_next.st = S_SSTORE;
                     end
                  end else if (r_reg.widx == TCB_DADDR) begin
                     if ((r_reg.cw[CW_CHAIN] && is_odd(r_reg.p5))
                         || (r_reg.cw[CW_SE] && is_odd(r_reg.p4))) begin
                        exc = 1'b1;
                        exc_bits[ISB_SPEC_CHECK] = 1'b1;
                     end else begin
                        r_next.st = S_XFER;
                        r_next.supp = 1'b0;
                        if (r_reg.cw[CW_PCI] && r_reg.ctrl[CTRL_PCI_EN]) begin
                           r_next.irq_pend = 1'b1;
                           raise = 1'b1;
                           r_next.irq_term = 1'b0;
                           r_next.irq_cc = IRQ_CC_PCI;
                           r_next.irq_info = r_reg.p3[15:8];
                        end
                     end
                  end
               end
            end
         end
         S_XFER: begin
            if (!r_reg.cs_req) begin
               if (r_reg.cnt == 16'h0000) begin
                  done_dcb = 1'b1;
               end else if (i_dev_exception) begin
                  if (r_reg.cw[CW_SE] && r_reg.ctrl[CTRL_SE_EN]) begin
                     r_next.supp = 1'b1;
                     done_dcb = 1'b1;
                  end else begin
                     exc = 1'b1;
                     exc_bits[ISB_DEV_EXCEPT] = 1'b1;
                  end
               end else if (!r_reg.cw[CW_INPUT] || dev_take) begin
                  r_next.cs_req = 1'b1;
                  r_next.cs_write = r_reg.cw[CW_INPUT];
                  r_next.cs_byte = (xstep == 16'h0001);
                  r_next.cs_addr = r_reg.daddr;
                  r_next.cs_wdata = i_dev_data;
                  r_next.resaddr = r_reg.daddr;
               end
            end else if (i_cs_grant) begin
               r_next.cs_req = 1'b0;
               if (i_cs_error) begin
                  exc = 1'b1;
                  exc_bits[ISB_STORAGE_ERR] = 1'b1;
               end else begin
                  r_next.cnt = r_reg.cnt - xstep;
                  r_next.rescnt = r_reg.rescnt - xstep;
                  r_next.daddr = r_reg.daddr + xstep;
                  if (!r_reg.cw[CW_INPUT]) begin
                     r_next.dev_wstrobe = 1'b1;
                     r_next.dev_wdata = i_cs_rdata;
                  end
               end
            end
         end
         S_RSB: begin
            if (!r_reg.cs_req) begin
               r_next.cs_req = 1'b1;
               r_next.cs_write = 1'b1;
               r_next.cs_byte = 1'b0;
               r_next.cs_addr = word_at(r_reg.p4, r_reg.widx);
               r_next.resaddr = word_at(r_reg.p4, r_reg.widx);
               r_next.cs_wdata = 16'h0000;
               if (r_reg.widx == 3'h0) begin
                  r_next.cs_wdata = r_reg.rescnt;
               end else begin
                  r_next.cs_wdata[RSB_EOC] = ~r_reg.cw[CW_CHAIN];
                  r_next.cs_wdata[RSB_NE] = ~r_reg.supp;
                  r_next.cs_wdata[RSB_FLAG] = r_reg.supp;
               end
            end else if (i_cs_grant) begin
               r_next.cs_req = 1'b0;
               r_next.widx = r_reg.widx + 3'h1;
               if (i_cs_error) begin
                  exc = 1'b1;
                  exc_bits[ISB_STORAGE_ERR] = 1'b1;
               end else if (r_reg.widx == RSB_WORDS - 3'h1) begin
                  done_dcb = 1'b1;
               end
            end
         end
         S_SSTORE: begin
            if (!r_reg.cs_req) begin
               if ({12'h000, r_reg.widx, 1'b0} == r_reg.cnt) begin
                  done_dcb = 1'b1;
               end else begin
                  r_next.cs_req = 1'b1;
                  r_next.cs_write = 1'b1;
                  r_next.cs_byte = 1'b0;
                  r_next.cs_addr = word_at(r_reg.daddr, r_reg.widx);
                  unique case (r_reg.widx)
                     3'h0: r_next.cs_wdata = r_reg.resaddr;
                     3'h1: r_next.cs_wdata = r_reg.rescnt;
                     default: r_next.cs_wdata = {8'h00, r_reg.interrupt_status_byte};
                  endcase
               end
            end else if (i_cs_grant) begin
               r_next.cs_req = 1'b0;
               r_next.widx = r_reg.widx + 3'h1;
               if (i_cs_error) begin
                  exc = 1'b1; // residual address and count untouched
                  exc_bits[ISB_STORAGE_ERR] = 1'b1;
               end
            end
         end
         default: r_next.st = S_IDLE;
      endcase

      // block finished: suppressed status first, then chain or end
      if (done_dcb) begin
         if (r_reg.st == S_XFER && r_reg.cw[CW_SE] && r_reg.ctrl[CTRL_SE_EN]) begin
            r_next.st = S_RSB;
            r_next.widx = 3'h0;
         end else if (!r_reg.sts_op && r_reg.cw[CW_CHAIN]) begin
            r_next.dcb_addr = r_reg.p5;
            r_next.widx = TCB_CTRL;
            r_next.st = S_FETCH;
         end else begin
            r_next.st = S_IDLE;
            r_next.irq_pend = 1'b1;
            raise = 1'b1;
            r_next.irq_term = 1'b1;
            r_next.irq_cc = IRQ_CC_DEV_END;
            r_next.irq_info = 8'h00;
         end
      end
      if (exc) begin
         r_next.st = S_IDLE;
         r_next.cs_req = 1'b0;
         r_next.interrupt_status_byte = r_next.interrupt_status_byte | exc_bits;
         r_next.irq_pend = 1'b1;
         raise = 1'b1;
         r_next.irq_term = 1'b1;
         r_next.irq_cc = IRQ_CC_EXCEPT;
         r_next.irq_info = r_next.interrupt_status_byte;
      end

      // accepted interrupt delivers its code; busy ends only on a terminating one
      if (irq_show && i_irq_accept) begin
         r_next.irq_valid = 1'b1;
         r_next.irq_out_cc = r_reg.irq_cc;
         r_next.irq_out_id = {DEV_ADDR, r_reg.irq_info};
         if (r_reg.irq_term) begin
            r_next.busy = 1'b0;
         end
         // a condition raised in this same cycle must outlive the accept
         if (!raise) begin
            r_next.irq_pend = 1'b0;
         end
      end

      // residual address survives every reset except power-on
      if (abort) begin
         r_next.st = S_IDLE;
         r_next.busy = 1'b0;
         r_next.cs_req = 1'b0;
         r_next.irq_pend = 1'b0;
         r_next.rescnt = 16'h0000;
         if (i_sys_reset || i_halt_io) begin
            r_next.interrupt_status_byte = 8'h00;
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         r_reg <= '0;
         r_reg.ctrl <= CTRL_RESET;
         r_reg.resaddr <= WORD_DEVICE ? RESADDR_POR_WORD : RESADDR_POR_BYTE;
      end else begin
         r_reg <= r_next;
      end
   end

   assign o_icc_valid = r_reg.icc_valid;
   assign o_icc = r_reg.icc;
   assign o_icc_data = r_reg.icc_data;
   assign o_cs_req = r_reg.cs_req;
   assign o_cs_write = r_reg.cs_write;
   assign o_cs_byte = r_reg.cs_byte;
   assign o_cs_addr = r_reg.cs_addr;
   assign o_cs_wdata = r_reg.cs_wdata;
   assign o_burst = (r_reg.st == S_XFER) & r_reg.cw[CW_BURST];
   assign o_irq_req = irq_show;
   assign o_irq_level = r_reg.level;
   assign o_irq_valid = r_reg.irq_valid;
   assign o_irq_cc = r_reg.irq_out_cc;
   assign o_irq_id = r_reg.irq_out_id;
   assign o_dev_ready = dev_take;
   assign o_dev_wstrobe = r_reg.dev_wstrobe;
   assign o_dev_wdata = r_reg.dev_wdata;
   assign o_reg_rdata = r_reg.rdata;

   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   a_icc_follows: assert property (i_cmd_valid |=> o_icc_valid)
      else $error("no condition code after command");
   a_start_ok: assert property (i_cmd_valid && i_cmd_code == CMD_START && !r_reg.busy
      && !i_cmd_data[0] && !abort |=> o_icc == ICC_OK && r_reg.busy)
      else $error("accepted start did not report code seven");
   a_start_busy: assert property (i_cmd_valid && i_cmd_code == CMD_START && r_reg.busy
      |=> o_icc == ICC_BUSY)
      else $error("start while busy not refused");
   a_irq_masked: assert property (o_irq_req |-> r_reg.mask && !o_burst)
      else $error("interrupt offered while masked or in burst");
   a_busy_hold: assert property (r_reg.busy && !r_reg.mask && !abort && !i_cmd_valid
      |=> r_reg.busy)
      else $error("masked device dropped busy");
   a_accept_code: assert property (o_irq_req && i_irq_accept && !abort
      |=> o_irq_valid && o_irq_cc == $past(r_reg.irq_cc) ##1 !o_irq_valid)
      else $error("accepted interrupt code wrong");
   a_count_step: assert property (r_reg.st == S_XFER && r_reg.cs_req && i_cs_grant
      && !i_cs_error && !abort && !(i_cmd_valid && i_cmd_code == CMD_DEV_RESET)
      |=> r_reg.rescnt == $past(r_reg.rescnt) - $past(xstep))
      else $error("residual count did not follow transfer");
   a_rsb_count: assert property (r_reg.st == S_RSB && !abort && !i_cmd_valid
      |=> $stable(r_reg.rescnt))
      else $error("residual count changed by status block store");
   a_status_addr: assert property (r_reg.sts_op && r_reg.st == S_SSTORE
      |=> $stable(r_reg.resaddr))
      else $error("status operation moved residual address");
endmodule

/* verif/cs_chan_model.sv */
// behavioural channel: storage, cycle-steal grants, prompt or slow
`timescale 1ns/1ps
module cs_chan_model (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // storage request from the device
   input wire logic i_req,
   input wire logic i_write,
   input wire logic [15:0] i_addr,
   input wire logic [15:0] i_wdata,
   // forced storage error on every grant
   input wire logic i_fail,
   // storage answer
   output logic o_grant,
   output logic o_error,
   output logic [15:0] o_rdata
);
   logic [15:0] mem [0:511];
   logic slow;
   logic [15:0] last;
   assign o_error = o_grant & i_fail;
   // released bus shows the inverse, never a stale word
   assign o_rdata = o_grant ? mem[i_addr[9:1]] : ~last;
   always @(posedge i_clk) begin
      if (i_rst) begin
         o_grant <= 1'b0;
         slow <= 1'b0;
         last <= 16'h0000;
      end else begin
         // grants only on every other clock, so a request may wait one extra cycle
         o_grant <= i_req && !o_grant && slow;
         slow <= ~slow;
         if (o_grant) last <= o_rdata;
         if (o_grant && i_write) mem[i_addr[9:1]] <= i_wdata;
      end
   end
endmodule

/* verif/cs_dev_tb.sv */
// self-checking bench: commands, cycle-steal blocks, interrupts, registers
`timescale 1ns/1ps
module cs_dev_tb;
   import cs_dev_pkg::*;
   logic clk = 0, rst = 1, halt = 0, cv = 0, rw = 0, rr = 0, acc = 0, fail = 0;
   logic [7:0] cc = 8'h00, ra = 8'h00;
   logic [15:0] cd = 16'h0000, wd = 16'h0000, rdata, icc_d, irq_id;
   logic req, wr, byt, grant, err, ivld, irq, irqv, burst;
   logic [15:0] addr, wdat, rd, dwd;
   logic [2:0] icc, irq_cc;
   int fails = 0, n_compared = 0, cyc = 0;
   always #4 clk = ~clk;
   cs_chan_model cs_chan_model_i (.i_clk(clk), .i_rst(rst), .i_req(req), .i_write(wr),
      .i_addr(addr), .i_wdata(wdat), .i_fail(fail), .o_grant(grant), .o_error(err),
      .o_rdata(rdata));
   cs_dev cs_dev_i (.i_ref_clk(clk), .i_rst(rst), .i_sys_reset(1'b0), .i_halt_io(halt),
      .i_machine_check(1'b0), .i_cmd_valid(cv), .i_cmd_code(cc), .i_cmd_data(cd),
      .o_icc_valid(ivld), .o_icc(icc), .o_icc_data(icc_d), .o_cs_req(req), .o_cs_write(wr),
      .o_cs_byte(byt), .o_cs_addr(addr), .o_cs_wdata(wdat), .o_burst(burst),
      .i_cs_grant(grant), .i_cs_error(err), .i_cs_rdata(rdata), .o_irq_req(irq),
      .o_irq_level(), .i_irq_accept(acc), .o_irq_valid(irqv), .o_irq_cc(irq_cc),
      .o_irq_id(irq_id), .i_dev_valid(1'b1), .i_dev_data(16'hC35A), .o_dev_ready(),
      .o_dev_wstrobe(), .o_dev_wdata(dwd), .i_dev_exception(1'b0), .i_reg_addr(ra),
      .i_reg_wdata(wd), .i_reg_wr(rw), .i_reg_rd(rr), .o_reg_rdata(rd));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("compared=%0d fails=%0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk) begin rr <= 1'b1; ra <= a; end
      @(posedge clk) rr <= 1'b0;
      @(negedge clk) chk(rd, exp);
   endtask
   task automatic cmd(input logic [7:0] c, input logic [15:0] d, input logic [2:0] exp);
      @(posedge clk) begin cv <= 1'b1; cc <= c; cd <= d; end
      @(posedge clk) cv <= 1'b0;
      @(negedge clk) chk({12'h000, ivld, icc}, {13'h0001, exp});
   endtask
   task automatic take_irq(input logic [2:0] exp);
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      @(posedge clk) acc <= 1'b1;
      @(posedge clk) acc <= 1'b0;
      @(negedge clk) chk({12'h000, irqv, irq_cc}, {13'h0001, exp});
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         give_verdict();
      end
   end
   initial begin
      // output block at 0100: 4 bytes from 0200; status block at 0140
      // status collection block at 0160 stores 3 words at 0240
      // chain at 0180: input 3 bytes to 0220, status to 01C0, then burst block at 01A0
      for (int i = 0; i < 8; i++) begin
         cs_chan_model_i.mem[9'h080 + i] = 16'h0000;
         cs_chan_model_i.mem[9'h0C0 + i] = 16'h0000;
         cs_chan_model_i.mem[9'h0D0 + i] = 16'h0000;
      end
      cs_chan_model_i.mem[9'h0B6] = 16'h0006;
      cs_chan_model_i.mem[9'h0B7] = 16'h0240;
      cs_chan_model_i.mem[9'h0C0] = 16'hE040;
      cs_chan_model_i.mem[9'h0C3] = 16'h5500;
      cs_chan_model_i.mem[9'h0C4] = 16'h01C0;
      cs_chan_model_i.mem[9'h0C5] = 16'h01A0;
      cs_chan_model_i.mem[9'h0C6] = 16'h0003;
      cs_chan_model_i.mem[9'h0C7] = 16'h0220;
      cs_chan_model_i.mem[9'h0D0] = 16'h0001;
      cs_chan_model_i.mem[9'h0D6] = 16'h0002;
      cs_chan_model_i.mem[9'h0D7] = 16'h0200;
      cs_chan_model_i.mem[9'h086] = 16'h0004;
      cs_chan_model_i.mem[9'h087] = 16'h0200;
      cs_chan_model_i.mem[9'h0A6] = 16'h0008;
      cs_chan_model_i.mem[9'h0A7] = 16'h0300;
      cs_chan_model_i.mem[9'h100] = 16'h1234;
      cs_chan_model_i.mem[9'h101] = 16'hABCD;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      reg_rd(REG_RESADDR, RESADDR_POR_WORD);
      cmd(CMD_PREPARE, 16'h0001, ICC_OK);
      cmd(CMD_START, 16'h0100, ICC_OK);
      cmd(CMD_START, 16'h0100, ICC_BUSY);
      take_irq(IRQ_CC_DEV_END);
      reg_rd(REG_RESCNT, 16'h0000);
      reg_rd(REG_RESADDR, 16'h0202);
      chk(dwd, 16'hABCD);
      // count above the maximum must be refused with a spec check
      cmd(CMD_START_STS, 16'h0140, ICC_OK);
      take_irq(IRQ_CC_EXCEPT);
      reg_rd(REG_DEVSTAT, 16'h0008);
      // valid status collection keeps the status byte and stores it last
      cmd(CMD_START_STS, 16'h0160, ICC_OK);
      take_irq(IRQ_CC_DEV_END);
      chk(cs_chan_model_i.mem[9'h120], 16'h0202);
      chk(cs_chan_model_i.mem[9'h121], 16'h0000);
      chk(cs_chan_model_i.mem[9'h122], 16'h0008);
      @(posedge clk) halt <= 1'b1;
      @(posedge clk) halt <= 1'b0;
      reg_rd(REG_DEVSTAT, 16'h0000);
      reg_rd(REG_RESADDR, 16'h0202);
      cmd(CMD_START, 16'h0101, ICC_REJECT);
      cmd(CMD_CONTROL, 16'h0001, ICC_OK);
      take_irq(IRQ_CC_DEV_END);
      // storage error on the first block word
      @(posedge clk) fail <= 1'b1;
      cmd(CMD_START, 16'h0100, ICC_OK);
      take_irq(IRQ_CC_EXCEPT);
      @(posedge clk) fail <= 1'b0;
      reg_rd(REG_RESADDR, 16'h0100);
      cmd(CMD_READ_STATUS, 16'h0000, ICC_OK);
      chk(icc_d, 16'h0004);
      reg_rd(REG_DEVSTAT, 16'h0000);
      // chained input block with status store and program interrupt, then burst
      cmd(CMD_START, 16'h0180, ICC_OK);
      take_irq(IRQ_CC_PCI);
      chk(irq_id, {DEV_ADDR, 8'h55});
      take_irq(IRQ_CC_DEV_END);
      reg_rd(REG_RESADDR, 16'h0200);
      chk(cs_chan_model_i.mem[9'h110], 16'hC35A);
      chk(cs_chan_model_i.mem[9'h0E0], 16'h0000);
      chk(cs_chan_model_i.mem[9'h0E1], 16'h4000);
      chk(dwd, 16'h1234);
      give_verdict();
   end
endmodule
